// File: common/usbctl_defines.svh
// Functional notes
// [R1] Setting module enable activates engine and clears all pingpong indicators.
// [R2] With enable clear, other control bits are ignored and device detaches.
// [R3] Enable also switches on regulator when configuration allows it.
// [R4] Firmware configures everything before setting enable.
// [R5] Bit 5 reads the live single-ended-zero state of the bus lines.
// [R6] Firmware watches bit 5 leaving SE0 to tell power-up from bus reset.
// [R7] While pointer reset bit is one, all pingpong pointers select even bank.
// [R8] Pointer reset bit is not self-clearing; firmware writes it to zero.
// [R9] Pointer reset bit is ignored when no pingpong buffering is configured.
// [R10] SETUP token sets the lockout flag; while set, token processing halts.
// [R11] Writing one to lockout does nothing; writing zero clears it.
// [R12] Pending descriptor events stay visible through the status FIFO during lockout.
// [R13] While resume bit is one, engine drives resume signaling on the bus.
// [R14] Firmware holds resume for 10 ms, then clears it.
// [R15] Suspend bit puts module and regulator in low power and stops engine clock.
// [R16] In suspend device stays attached with transceiver outputs idle.
// [R17] Firmware sets suspend after bus idle, clears after bus activity.
// [R18] Internal transceiver disable resets to zero, transceiver active.
// [R19] Speed select one means full speed, zero means low speed.
// [R20] Pull-up enable only acts when the internal transceiver is in use.
// [R21] Firmware sets speed, transceiver, pull-up only before enabling.
// [R22] Endpoint buffers sit in dual-ported memory located by descriptors.
// [R23] Pingpong field: 00 none, 01 EP0 OUT, 10 all, 11 all but EP0.
// [R24] Engine clock is 48 MHz at full speed, 6 MHz at low speed.
// [R25] Control bits 7 and 0 read zero and ignore writes.
`ifndef USBCTL_DEFINES_SVH
`define USBCTL_DEFINES_SVH
`define USBCTL_ADDR_W 4
`define USBCTL_OFS_CTRL 4'h0
`define USBCTL_OFS_CFG 4'h1
`define USBCTL_OFS_PPI 4'h2
`define USBCTL_CTRL_SUSP 1
`define USBCTL_CTRL_RESUME 2
`define USBCTL_CTRL_EN 3
`define USBCTL_CTRL_LOCK 4
`define USBCTL_CTRL_SE0 5
`define USBCTL_CTRL_PPRST 6
`define USBCTL_CFG_PP_LSB 0
`define USBCTL_CFG_FS 2
`define USBCTL_CFG_XOFF 3
`define USBCTL_CFG_PU 4
`define USBCTL_CTRL_RST 8'h00
`define USBCTL_CFG_RST 8'h00
`define USBCTL_CTRL_WMASK 8'h5e
`define USBCTL_CFG_WMASK 8'h1f
`endif

// File: common/usbctl_pkg.sv
package usbctl_pkg;
    typedef enum logic [1:0] {
        USBCTL_PP_NONE = 2'h0,
        USBCTL_PP_EP0OUT = 2'h1,
        USBCTL_PP_ALL = 2'h2,
        USBCTL_PP_NOEP0 = 2'h3
    } usbctl_pp_mode_t;
    typedef enum logic [2:0] {
        USBCTL_ST_DETACHED = 3'b001,
        USBCTL_ST_ACTIVE = 3'b010,
        USBCTL_ST_SUSPEND = 3'b100
    } usbctl_state_t;
endpackage : usbctl_pkg

// File: hdl/usbctl_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser; stage one is read by stage two only
module usbctl_sync #(
    parameter int WIDTH = 2,
    // Reset to the idle level of the inputs so no false event follows reset
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    initial begin
        if (WIDTH < 1) $error("usbctl_sync: WIDTH must be positive");
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end
    assign sync_o = sync_q;
endmodule : usbctl_sync

// File: hdl/usbctl_top.sv
`timescale 1ns/1ns
`include "usbctl_defines.svh"
module usbctl_top
    import usbctl_pkg::*;
#(
    parameter int NUM_EP = 16
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [`USBCTL_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic bus_dp_i,
    input wire logic bus_dm_i,
    input wire logic setup_token_i,
    input wire logic regulator_cfg_en_i,
    input wire logic [NUM_EP-1:0] pp_toggle_i,
    output logic [NUM_EP-1:0] pingpong_buffer_indicator_o,
    output logic engine_active_o,
    output logic attach_o,
    output logic pullup_on_o,
    output logic full_speed_o,
    output logic xcvr_internal_o,
    output logic regulator_on_o,
    output logic regulator_lowpower_o,
    output logic engine_clk_en_o,
    output logic packet_proc_en_o,
    output logic resume_drive_o,
    output logic xcvr_idle_o
);
    usbctl_state_t state_q, state_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] cfg_q, cfg_d;
    logic [NUM_EP-1:0] ppi_q, ppi_d;
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] lines_s;
    logic se0_live;
    logic en;
    logic pp_rst_eff;
    usbctl_pp_mode_t pp_mode;

    initial begin
        if (NUM_EP < 1 || NUM_EP > 16) $error("usbctl_top: NUM_EP must be 1..16");
    end

    // Bit set in the mask marks an endpoint that uses ping-pong in the given mode
    function automatic logic [NUM_EP-1:0] pp_used(input usbctl_pp_mode_t m); // see [R23]
        logic [NUM_EP-1:0] r;
        r = '0;
        case (m)
            USBCTL_PP_NONE: r = '0;
            USBCTL_PP_EP0OUT: r[0] = 1'b1;
            USBCTL_PP_ALL: r = '1;
            USBCTL_PP_NOEP0: begin
                r = '1;
                r[0] = 1'b0;
            end
            default: r = '0;
        endcase
        return r;
    endfunction : pp_used

    // Idle full-speed J is D+ high, D- low; a zero reset would fake an SE0
    usbctl_sync #(.WIDTH(2), .RST_VAL(2'b10)) u_line_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i({bus_dp_i, bus_dm_i}),
        .sync_o(lines_s)
    );

    assign se0_live = (lines_s == 2'b00); // see [R5]
    assign en = ctrl_q[`USBCTL_CTRL_EN];
    assign pp_mode = usbctl_pp_mode_t'(cfg_q[`USBCTL_CFG_PP_LSB +: 2]);
    // Pointer reset has no meaning without ping-pong buffering
    assign pp_rst_eff = en && ctrl_q[`USBCTL_CTRL_PPRST]
        && (pp_mode != USBCTL_PP_NONE); // see [R9]

    always_comb begin
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        if (reg_wr_i && reg_addr_i == `USBCTL_OFS_CTRL) begin
            // Bits 7, 0 and the live flag are not stored
            ctrl_d = reg_wdata_i & `USBCTL_CTRL_WMASK; // see [R25]
            // Lockout is clear-only from software
            ctrl_d[`USBCTL_CTRL_LOCK] = ctrl_q[`USBCTL_CTRL_LOCK]
                && reg_wdata_i[`USBCTL_CTRL_LOCK]; // see [R11]
        end
        if (reg_wr_i && reg_addr_i == `USBCTL_OFS_CFG) begin
            cfg_d = reg_wdata_i & `USBCTL_CFG_WMASK;
        end
        // Hardware set beats a same-cycle software clear
        if (en && setup_token_i) begin
            ctrl_d[`USBCTL_CTRL_LOCK] = 1'b1; // see [R10]
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            USBCTL_ST_DETACHED: if (en) state_d = USBCTL_ST_ACTIVE;
            USBCTL_ST_ACTIVE: begin
                if (!en) state_d = USBCTL_ST_DETACHED;
                else if (ctrl_q[`USBCTL_CTRL_SUSP]) state_d = USBCTL_ST_SUSPEND;
            end
            USBCTL_ST_SUSPEND: begin
                if (!en) state_d = USBCTL_ST_DETACHED;
                else if (!ctrl_q[`USBCTL_CTRL_SUSP]) state_d = USBCTL_ST_ACTIVE;
            end
            default: state_d = USBCTL_ST_DETACHED;
        endcase
    end

    always_comb begin
        ppi_d = ppi_q;
        if (state_q == USBCTL_ST_DETACHED && en) begin
            ppi_d = '0; // see [R1]
        end else if (pp_rst_eff) begin
            ppi_d = '0; // see [R7]
        // Lockout freezes toggles only; indicators stay readable to firmware
        end else if (en && state_q == USBCTL_ST_ACTIVE
            && !ctrl_q[`USBCTL_CTRL_LOCK]) begin // see [R12]
            ppi_d = ppi_q ^ (pp_toggle_i & pp_used(pp_mode));
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `USBCTL_OFS_CTRL: begin
                    rdata_d = ctrl_q & `USBCTL_CTRL_WMASK;
                    rdata_d[`USBCTL_CTRL_SE0] = se0_live; // see [R5]
                end
                `USBCTL_OFS_CFG: rdata_d = cfg_q;
                `USBCTL_OFS_PPI: rdata_d = 8'(ppi_q); // see [R22]
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= USBCTL_ST_DETACHED;
            ctrl_q <= `USBCTL_CTRL_RST;
            cfg_q <= `USBCTL_CFG_RST; // see [R18]
            ppi_q <= '0;
            rdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            ppi_q <= ppi_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs: attach, pull-up, regulator, clock, processing and resume gated by enable so a detached module stays inert
    assign reg_rdata_o = rdata_q;
    assign pingpong_buffer_indicator_o = ppi_q;
    assign engine_active_o = (state_q != USBCTL_ST_DETACHED); // see [R2]
    assign attach_o = en; // see [R16]
    assign xcvr_internal_o = !cfg_q[`USBCTL_CFG_XOFF];
    assign full_speed_o = cfg_q[`USBCTL_CFG_FS]; // see [R19]
    assign pullup_on_o = en && cfg_q[`USBCTL_CFG_PU] && !cfg_q[`USBCTL_CFG_XOFF]; // see [R20]
    assign regulator_on_o = en && regulator_cfg_en_i; // see [R3]
    assign regulator_lowpower_o = en && (state_q == USBCTL_ST_SUSPEND); // see [R15]
    // Gate only; the clock itself is stopped by the clock tree cell
    assign engine_clk_en_o = en && (state_q == USBCTL_ST_ACTIVE); // see [R15]
    // Enable gates too, so the cycle after detach already shows the engine idle
    assign packet_proc_en_o = en && (state_q == USBCTL_ST_ACTIVE)
        && !ctrl_q[`USBCTL_CTRL_LOCK]; // see [R10]
    assign resume_drive_o = en && ctrl_q[`USBCTL_CTRL_RESUME]; // see [R13]
    assign xcvr_idle_o = (state_q != USBCTL_ST_ACTIVE) && !resume_drive_o; // see [R16]

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_enable_rise;
        !en ##1 en;
    endsequence
    sequence s_ppi_cleared;
        ##1 (ppi_q == '0);
    endsequence

    property p_enable_clears_ppi;
        s_enable_rise |-> s_ppi_cleared;
    endproperty
    a_enable_clears_ppi: assert property (p_enable_clears_ppi) // see [R1]
        else $error("Indicators not cleared on enable");

    property p_detached_inert;
        !en |-> !packet_proc_en_o && !resume_drive_o && !pullup_on_o && !regulator_on_o;
    endproperty
    a_detached_inert: assert property (p_detached_inert) // see [R2]
        else $error("Detached module drives bus functions");

    property p_reg_follows_en;
        regulator_on_o == (en && regulator_cfg_en_i);
    endproperty
    a_reg_follows_en: assert property (p_reg_follows_en) // see [R3]
        else $error("Regulator state wrong");

    property p_se0_read;
        reg_rd_i && reg_addr_i == `USBCTL_OFS_CTRL
            |=> reg_rdata_o[`USBCTL_CTRL_SE0] == $past(se0_live);
    endproperty
    a_se0_read: assert property (p_se0_read) // see [R5]
        else $error("Live SE0 flag misread");

    property p_pprst_even;
        pp_rst_eff && !(setup_token_i) |=> ppi_q == '0;
    endproperty
    a_pprst_even: assert property (p_pprst_even) // see [R7]
        else $error("Pointers not forced even");

    property p_setup_locks;
        en && setup_token_i |=> ctrl_q[`USBCTL_CTRL_LOCK] ##0 !packet_proc_en_o;
    endproperty
    a_setup_locks: assert property (p_setup_locks) // see [R10]
        else $error("SETUP did not lock out processing");

    property p_sw_cannot_set_lock;
        !ctrl_q[`USBCTL_CTRL_LOCK] && !(en && setup_token_i) |=> !ctrl_q[`USBCTL_CTRL_LOCK];
    endproperty
    a_sw_cannot_set_lock: assert property (p_sw_cannot_set_lock) // see [R11]
        else $error("Lockout set without SETUP");

    property p_suspend_clock;
        en && ctrl_q[`USBCTL_CTRL_SUSP] |=> !engine_clk_en_o && regulator_lowpower_o;
    endproperty
    a_suspend_clock: assert property (p_suspend_clock) // see [R15]
        else $error("Suspend did not stop engine clock");

    property p_suspend_attached;
        regulator_lowpower_o |-> attach_o;
    endproperty
    a_suspend_attached: assert property (p_suspend_attached) // see [R16]
        else $error("Suspended device detached");

    property p_pullup_internal;
        cfg_q[`USBCTL_CFG_XOFF] |-> !pullup_on_o;
    endproperty
    a_pullup_internal: assert property (p_pullup_internal) // see [R20]
        else $error("Pull-up on with external transceiver");

    property p_unimpl_zero;
        reg_rd_i |=> reg_rdata_o[7] == 1'b0 || $past(reg_addr_i) != `USBCTL_OFS_CTRL;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) // see [R25]
        else $error("Unimplemented control bit reads one");
endmodule : usbctl_top

// File: test/usbctl_host_model.sv
`timescale 1ns/1ns
module usbctl_host_model (
    input wire logic se0_req_i,
    input wire logic setup_req_i,
    output logic bus_dp_o,
    output logic bus_dm_o,
    output logic setup_token_o
);
    // Idle lines show full-speed J; SE0 pulls both low
    // No bit timing here; the line rate belongs to the engine clock
    assign bus_dp_o = !se0_req_i;
    assign bus_dm_o = 1'b0;
    assign setup_token_o = setup_req_i;
endmodule : usbctl_host_model

// File: test/usbctl_top_bench.sv
`timescale 1ns/1ns
`include "usbctl_defines.svh"
module usbctl_top_bench;
    import usbctl_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic bus_dp_i, bus_dm_i, setup_token_i;
    logic se0_req = 1'b0;
    logic setup_req = 1'b0;
    logic regulator_cfg_en_i = 1'b1;
    logic [15:0] pp_toggle_i = 16'h0000;
    logic [15:0] pingpong_buffer_indicator_o;
    logic engine_active_o, attach_o, pullup_on_o, full_speed_o, xcvr_internal_o;
    logic regulator_on_o, regulator_lowpower_o, engine_clk_en_o, packet_proc_en_o;
    logic resume_drive_o, xcvr_idle_o;
    int fails = 0;
    int checks = 0;
    // Indicators after toggling all endpoints once in modes none, EP0 OUT, all, all but EP0
    logic [15:0] ppi_exp [4] = '{16'h0003, 16'h0002, 16'hfffd, 16'h0003};
    usbctl_top #(.NUM_EP(16)) i_dut (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_dp_i, .bus_dm_i, .setup_token_i,
        .regulator_cfg_en_i, .pp_toggle_i, .pingpong_buffer_indicator_o, .engine_active_o,
        .attach_o, .pullup_on_o, .full_speed_o, .xcvr_internal_o, .regulator_on_o,
        .regulator_lowpower_o, .engine_clk_en_o, .packet_proc_en_o, .resume_drive_o,
        .xcvr_idle_o);
    usbctl_host_model i_host (.se0_req_i(se0_req), .setup_req_i(setup_req),
        .bus_dp_o(bus_dp_i), .bus_dm_o(bus_dm_i), .setup_token_o(setup_token_i));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Every access starts on its own edge so no strobe is driven twice in a step
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
    endtask : rd
    task sett(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : sett
    task tog(input logic [15:0] m);
        @(posedge clk_sys_i);
        pp_toggle_i <= m;
        @(posedge clk_sys_i);
        pp_toggle_i <= 16'h0000;
        sett(1);
    endtask : tog
    task t_reset();
        rd(`USBCTL_OFS_CTRL, 8'h00);
        rd(`USBCTL_OFS_CFG, 8'h00);
        chk("xcvr_int", 16'h1, {15'h0, xcvr_internal_o});
    endtask : t_reset
    task t_cfg();
        // Configuration is written only while the module is detached
        wr(`USBCTL_OFS_CFG, 8'hff);
        rd(`USBCTL_OFS_CFG, 8'h1f);
        chk("fs", 16'h1, {15'h0, full_speed_o});
        wr(`USBCTL_OFS_CTRL, 8'h08);
        sett(1);
        chk("pullup ext", 16'h0, {15'h0, pullup_on_o});
        wr(`USBCTL_OFS_CTRL, 8'h00);
        wr(`USBCTL_OFS_CFG, 8'h12);
        sett(0);
        chk("ls", 16'h0, {15'h0, full_speed_o});
    endtask : t_cfg
    task t_enable();
        wr(`USBCTL_OFS_CTRL, 8'h08);
        sett(1);
        tog(16'ha5a5);
        chk("ppi", 16'ha5a5, pingpong_buffer_indicator_o);
        wr(`USBCTL_OFS_CTRL, 8'h00);
        wr(`USBCTL_OFS_CTRL, 8'h08);
        sett(1);
        chk("ppi", 16'h0000, pingpong_buffer_indicator_o);
        chk("active", 16'h1, {15'h0, engine_active_o});
        chk("reg on", 16'h1, {15'h0, regulator_on_o});
        chk("pullup", 16'h1, {15'h0, pullup_on_o});
        @(posedge clk_sys_i);
        regulator_cfg_en_i <= 1'b0;
        sett(1);
        chk("reg off", 16'h0, {15'h0, regulator_on_o});
        @(posedge clk_sys_i);
        regulator_cfg_en_i <= 1'b1;
    endtask : t_enable
    task t_disabled();
        wr(`USBCTL_OFS_CTRL, 8'h00);
        wr(`USBCTL_OFS_CTRL, 8'h46);
        sett(1);
        chk("attach", 16'h0, {15'h0, attach_o});
        chk("resume", 16'h0, {15'h0, resume_drive_o});
        chk("lowpwr", 16'h0, {15'h0, regulator_lowpower_o});
        wr(`USBCTL_OFS_CTRL, 8'h08);
    endtask : t_disabled
    task t_se0();
        se0_req <= 1'b1;
        sett(4);
        rd(`USBCTL_OFS_CTRL, 8'h28);
        @(posedge clk_sys_i);
        se0_req <= 1'b0;
        sett(4);
        // Firmware sees the lines leave SE0
        rd(`USBCTL_OFS_CTRL, 8'h08);
    endtask : t_se0
    task t_lock();
        @(posedge clk_sys_i);
        setup_req <= 1'b1;
        @(posedge clk_sys_i);
        setup_req <= 1'b0;
        sett(1);
        chk("pkt en", 16'h0, {15'h0, packet_proc_en_o});
        rd(`USBCTL_OFS_CTRL, 8'h18);
        wr(`USBCTL_OFS_CTRL, 8'h08);
        sett(1);
        chk("pkt en", 16'h1, {15'h0, packet_proc_en_o});
        wr(`USBCTL_OFS_CTRL, 8'h18);
        rd(`USBCTL_OFS_CTRL, 8'h08);
    endtask : t_lock
    task t_pprst();
        tog(16'h00ff);
        wr(`USBCTL_OFS_CTRL, 8'h48);
        sett(1);
        chk("ppi rst", 16'h0000, pingpong_buffer_indicator_o);
        tog(16'h0f0f);
        chk("ppi hold", 16'h0000, pingpong_buffer_indicator_o);
        wr(`USBCTL_OFS_CTRL, 8'h08);
        tog(16'h0003);
        chk("ppi", 16'h0003, pingpong_buffer_indicator_o);
        for (int m = 0; m < 4; m++) begin
            wr(`USBCTL_OFS_CFG, 8'h10 | 8'(m));
            rd(`USBCTL_OFS_CFG, 8'h10 | 8'(m));
            tog(16'hffff);
            chk("ppi mode", ppi_exp[m], pingpong_buffer_indicator_o);
        end
        wr(`USBCTL_OFS_CFG, 8'h10);
        wr(`USBCTL_OFS_CTRL, 8'h48);
        tog(16'h0030);
        chk("ppi", 16'h0003, pingpong_buffer_indicator_o);
        rd(`USBCTL_OFS_PPI, 8'h03);
        wr(`USBCTL_OFS_CTRL, 8'h08);
    endtask : t_pprst
    task t_power();
        // Host lines rest at idle J here, standing in for the bus-idle event
        wr(`USBCTL_OFS_CTRL, 8'h0a);
        sett(1);
        chk("clk en", 16'h0, {15'h0, engine_clk_en_o});
        chk("lowpwr", 16'h1, {15'h0, regulator_lowpower_o});
        chk("attach", 16'h1, {15'h0, attach_o});
        chk("idle", 16'h1, {15'h0, xcvr_idle_o});
        // A real wake-up holds resume far longer; a few cycles show the drive
        wr(`USBCTL_OFS_CTRL, 8'h0c);
        sett(1);
        chk("resume", 16'h1, {15'h0, resume_drive_o});
        chk("idle", 16'h0, {15'h0, xcvr_idle_o});
        wr(`USBCTL_OFS_CTRL, 8'h89);
        rd(`USBCTL_OFS_CTRL, 8'h08);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        rd(`USBCTL_OFS_CFG, 8'h10);
    endtask : t_power
    // Ceiling sits well above the roughly 135 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fails++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_cfg();
        t_enable();
        t_disabled();
        t_se0();
        t_lock();
        t_pprst();
        t_power();
        finish_test();
    end
endmodule : usbctl_top_bench
